// file: inc/crbcd_cfg.svh
/*
  Constants for the read-modify-write, branch and control decoder:
  opcodes, field positions, reset values and cycle targets.
  Assumes inclusion by bare name from the core only.
*/
`ifndef CRBCD_CFG_SVH
`define CRBCD_CFG_SVH

// high nibble of the read-modify-write group selects the addressing form
`define CRBCD_MODE_DIR 4'h3
`define CRBCD_MODE_INHA 4'h4
`define CRBCD_MODE_INHX 4'h5
`define CRBCD_MODE_IX1 4'h6
`define CRBCD_MODE_IX 4'h7
`define CRBCD_MODE_BRBIT 4'h0
`define CRBCD_MODE_BITSC 4'h1

// low nibble of the read-modify-write group selects the operation
`define CRBCD_FN_NEG 4'h0
`define CRBCD_FN_COM 4'h3
`define CRBCD_FN_LSR 4'h4
`define CRBCD_FN_ROR 4'h6
`define CRBCD_FN_ASR 4'h7
`define CRBCD_FN_LSL 4'h8
`define CRBCD_FN_ROL 4'h9
`define CRBCD_FN_DEC 4'hA
`define CRBCD_FN_INC 4'hC
`define CRBCD_FN_TST 4'hD
`define CRBCD_FN_CLR 4'hF

`define CRBCD_OPC_ACC_TO_INDEX_COPY 8'h97
`define CRBCD_OPC_INDEX_TO_ACC_COPY 8'h9F
`define CRBCD_OPC_STOP 8'h8E
`define CRBCD_OPC_WAIT 8'h8F
`define CRBCD_OPC_JUMP_UNCOND_DIR 8'hBC

// flag positions in flags_q
`define CRBCD_FLAG_C 0
`define CRBCD_FLAG_Z 1
`define CRBCD_FLAG_N 2
`define CRBCD_FLAG_I 3
`define CRBCD_FLAG_H 4

`define CRBCD_RST_PC 16'h0000
`define CRBCD_RST_FLAGS 5'h08
`define CRBCD_PAGE0_HI 8'h00

// least cycles per addressing form
`define CRBCD_CYC_DIR 4'h5
`define CRBCD_CYC_INH 4'h3
`define CRBCD_CYC_IX1 4'h6
`define CRBCD_CYC_IX 4'h5
`define CRBCD_CYC_BITSC 4'h5
`define CRBCD_CYC_NONE 4'h0

`endif

// file: inc/crbcd_pkg.sv
/*
  Types for the read-modify-write, branch and control decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package crbcd_pkg;

  typedef enum logic [2:0] {
    S_FETCH,
    S_OPCODE,
    S_OPERAND,
    S_DATA,
    S_REL,
    S_DONE,
    S_HALT
  } crbcd_state_t;

  typedef enum logic [3:0] {
    ALU_NEG,
    ALU_COM,
    ALU_LSR,
    ALU_ROR,
    ALU_ASR,
    ALU_LSL,
    ALU_ROL,
    ALU_DEC,
    ALU_INC,
    ALU_TST,
    ALU_CLR
  } crbcd_alu_op_t;

endpackage : crbcd_pkg

// file: rtl/crbcd_alu.sv
/*
  Modify stage of read-modify-write: one operand in, result and flags out.
  Assumes the caller holds the operand and old carry steady for the cycle.
*/
module crbcd_alu (
  input wire crbcd_pkg::crbcd_alu_op_t op,
  input wire logic [7:0] din,
  input wire logic cin,
  output logic [7:0] dout,
  output logic flag_n,
  output logic flag_z,
  output logic flag_c,
  output logic write_back
);

  always_comb begin
    dout = din;
    flag_c = cin;
    write_back = 1'b1;
    case (op)
      crbcd_pkg::ALU_NEG: begin
        dout = 8'h00 - din;
        flag_c = (din != 8'h00);
      end
      crbcd_pkg::ALU_COM: begin
        dout = ~din;
        flag_c = 1'b1;
      end
      crbcd_pkg::ALU_LSR: begin
        dout = {1'b0, din[7:1]};
        flag_c = din[0];
      end
      crbcd_pkg::ALU_ROR: begin
        dout = {cin, din[7:1]}; // RULE_15
        flag_c = din[0]; // RULE_15
      end
      crbcd_pkg::ALU_ASR: begin
        dout = {din[7], din[7:1]};
        flag_c = din[0];
      end
      crbcd_pkg::ALU_LSL: begin
        dout = {din[6:0], 1'b0}; // RULE_14
        flag_c = din[7];
      end
      crbcd_pkg::ALU_ROL: begin
        dout = {din[6:0], cin}; // RULE_15
        flag_c = din[7]; // RULE_15
      end
      crbcd_pkg::ALU_DEC: dout = din - 8'h01;
      crbcd_pkg::ALU_INC: dout = din + 8'h01;
      crbcd_pkg::ALU_TST: write_back = 1'b0; // RULE_04
      crbcd_pkg::ALU_CLR: dout = 8'h00;
      default: write_back = 1'b0;
    endcase
    flag_n = dout[7];
    flag_z = (dout == 8'h00);
  end

endmodule : crbcd_alu

// file: rtl/crbcd_core.sv
/*
  Sequencer for read-modify-write, bit set/clear, branch-on-bit, direct jump
  and control instructions (register copies, stop, wait).
  Assumes memory answers a read in the same cycle as the registered read strobe
  and takes a write in the cycle its strobe is high.
*/
// Contract
// [RULE_01] Read-modify-write reads target, alters it, writes back to the same place.
// [RULE_02] Software avoids read-modify-write on write-only registers.
// [RULE_03] Bit set and bit clear exist only in direct form.
// [RULE_04] Test-for-negative-or-zero updates flags and writes nothing back.
// [RULE_05] Branch-on-bit is opcode, page-zero address, signed displacement.
// [RULE_06] Bit number and set/clear sense come from the opcode.
// [RULE_07] Taken branch adds signed displacement to the next instruction address.
// [RULE_08] Branch-on-bit always copies the tested bit into carry.
// [RULE_09] Untaken branch continues with the following instruction.
// [RULE_10] Any bit in the first 256 bytes can be set or cleared.
// [RULE_11] Stop halts the oscillator and enables the interrupt pin.
// [RULE_12] Wait halts the CPU clock and enables interrupts.
// [RULE_13] Register copies move accumulator and index without memory access.
// [RULE_14] Shift-left is one operation at 38/48/58/68/78 with 5/3/3/6/5 cycles.
// [RULE_15] Rotates pass through carry in both directions.
// [RULE_16] Direct address high byte is forced to zero.
// [RULE_17] Memory read-modify-write reads then writes the same effective address.
`include "crbcd_cfg.svh"

module crbcd_core (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic irq_n_pin,
  output logic osc_stop,
  output logic cpu_clk_stop,
  output logic irq_pin_en,
  output logic [7:0] acc_value,
  output logic [7:0] idx_value,
  output logic [4:0] flags_value,
  output logic [15:0] pc_value,
  output logic instr_done
);

  crbcd_pkg::crbcd_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] ea_q, ea_d;
  logic [7:0] ir_q, ir_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] idx_q, idx_d;
  logic [4:0] flags_q, flags_d;
  logic [3:0] cyc_q, cyc_d;
  logic [15:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic [7:0] wdata_q, wdata_d;
  logic osc_stop_q, osc_stop_d;
  logic clk_stop_q, clk_stop_d;
  logic done_q, done_d;
  logic bit_q, bit_d;
  // irq pin synchroniser; only stage two reads stage one
  logic irq_s1_q, irq_s2_q, irq_s3_q, irq_lvl_q;
  logic irq_lvl_d;

  logic [3:0] mode;
  logic [3:0] fn;
  logic [7:0] alu_in;
  logic [7:0] alu_out;
  logic alu_n, alu_z, alu_c, alu_wb;
  crbcd_pkg::crbcd_alu_op_t alu_op;
  logic [15:0] next_pc;
  logic [7:0] bit_mask;

  assign mode = ir_q[7:4];
  assign fn = ir_q[3:0];
  assign bit_mask = 8'h01 << ir_q[3:1]; // RULE_06

  function automatic crbcd_pkg::crbcd_alu_op_t fn_to_op(input logic [3:0] f);
    case (f)
      `CRBCD_FN_NEG: fn_to_op = crbcd_pkg::ALU_NEG;
      `CRBCD_FN_COM: fn_to_op = crbcd_pkg::ALU_COM;
      `CRBCD_FN_LSR: fn_to_op = crbcd_pkg::ALU_LSR;
      `CRBCD_FN_ROR: fn_to_op = crbcd_pkg::ALU_ROR;
      `CRBCD_FN_ASR: fn_to_op = crbcd_pkg::ALU_ASR;
      `CRBCD_FN_LSL: fn_to_op = crbcd_pkg::ALU_LSL;
      `CRBCD_FN_ROL: fn_to_op = crbcd_pkg::ALU_ROL;
      `CRBCD_FN_DEC: fn_to_op = crbcd_pkg::ALU_DEC;
      `CRBCD_FN_INC: fn_to_op = crbcd_pkg::ALU_INC;
      `CRBCD_FN_TST: fn_to_op = crbcd_pkg::ALU_TST;
      `CRBCD_FN_CLR: fn_to_op = crbcd_pkg::ALU_CLR;
      default: fn_to_op = crbcd_pkg::ALU_TST;
    endcase
  endfunction : fn_to_op

  // undefined low nibbles change no flags and nothing is written
  function automatic logic fn_valid(input logic [3:0] f);
    fn_valid = (f != 4'h1) && (f != 4'h2) && (f != 4'h5) && (f != 4'hB) && (f != 4'hE);
  endfunction : fn_valid

  function automatic logic [3:0] cyc_target(input logic [3:0] m);
    case (m)
      `CRBCD_MODE_DIR: cyc_target = `CRBCD_CYC_DIR; // RULE_14
      `CRBCD_MODE_INHA: cyc_target = `CRBCD_CYC_INH; // RULE_14
      `CRBCD_MODE_INHX: cyc_target = `CRBCD_CYC_INH; // RULE_14
      `CRBCD_MODE_IX1: cyc_target = `CRBCD_CYC_IX1; // RULE_14
      `CRBCD_MODE_IX: cyc_target = `CRBCD_CYC_IX; // RULE_14
      `CRBCD_MODE_BITSC: cyc_target = `CRBCD_CYC_BITSC;
      default: cyc_target = `CRBCD_CYC_NONE;
    endcase
  endfunction : cyc_target

  assign alu_op = fn_to_op(fn); // RULE_14
  assign alu_in = (mode == `CRBCD_MODE_INHA) ? acc_q :
                  (mode == `CRBCD_MODE_INHX) ? idx_q : mem_rdata;

  crbcd_alu u_alu (
    .op(alu_op),
    .din(alu_in),
    .cin(flags_q[`CRBCD_FLAG_C]),
    .dout(alu_out),
    .flag_n(alu_n),
    .flag_z(alu_z),
    .flag_c(alu_c),
    .write_back(alu_wb)
  );

  // displacement is sign-extended; pc still points at the displacement, so next_pc is past it
  assign next_pc = pc_q + 16'h0001;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    ea_d = ea_q;
    ir_d = ir_q;
    acc_d = acc_q;
    idx_d = idx_q;
    flags_d = flags_q;
    cyc_d = cyc_q + 4'h1;
    addr_d = addr_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    wdata_d = wdata_q;
    osc_stop_d = osc_stop_q;
    clk_stop_d = clk_stop_q;
    done_d = 1'b0;
    bit_d = bit_q;
    case (state_q)
      crbcd_pkg::S_FETCH: begin
        addr_d = pc_q;
        rd_d = 1'b1;
        state_d = crbcd_pkg::S_OPCODE;
      end
      crbcd_pkg::S_OPCODE: begin
        ir_d = mem_rdata;
        pc_d = next_pc;
        state_d = crbcd_pkg::S_OPERAND;
        addr_d = next_pc;
        rd_d = 1'b1;
        if (mem_rdata == `CRBCD_OPC_ACC_TO_INDEX_COPY) begin
          idx_d = acc_q; // RULE_13
          state_d = crbcd_pkg::S_DONE;
          rd_d = 1'b0;
        end else if (mem_rdata == `CRBCD_OPC_INDEX_TO_ACC_COPY) begin
          acc_d = idx_q; // RULE_13
          state_d = crbcd_pkg::S_DONE;
          rd_d = 1'b0;
        end else if (mem_rdata == `CRBCD_OPC_STOP || mem_rdata == `CRBCD_OPC_WAIT) begin
          flags_d[`CRBCD_FLAG_I] = 1'b0; // RULE_11 RULE_12
          osc_stop_d = (mem_rdata == `CRBCD_OPC_STOP); // RULE_11
          clk_stop_d = 1'b1; // RULE_12
          state_d = crbcd_pkg::S_HALT;
          rd_d = 1'b0;
        end else if (mem_rdata[7:4] == `CRBCD_MODE_INHA ||
                     mem_rdata[7:4] == `CRBCD_MODE_INHX) begin
          // register operand is modified in place on the next state
          state_d = crbcd_pkg::S_DATA;
          rd_d = 1'b0;
        end else if (mem_rdata[7:4] == `CRBCD_MODE_IX) begin
          ea_d = {`CRBCD_PAGE0_HI, idx_q};
          addr_d = {`CRBCD_PAGE0_HI, idx_q};
          state_d = crbcd_pkg::S_DATA;
        end
      end
      crbcd_pkg::S_OPERAND: begin
        pc_d = next_pc;
        rd_d = 1'b1;
        state_d = crbcd_pkg::S_DATA;
        if (mode == `CRBCD_MODE_IX1) begin
          ea_d = {7'h00, {1'b0, idx_q} + {1'b0, mem_rdata}};
        end else begin
          ea_d = {`CRBCD_PAGE0_HI, mem_rdata}; // RULE_16 RULE_05 RULE_10
        end
        addr_d = ea_d;
        if (ir_q == `CRBCD_OPC_JUMP_UNCOND_DIR) begin
          pc_d = {`CRBCD_PAGE0_HI, mem_rdata}; // RULE_16
          rd_d = 1'b0;
          state_d = crbcd_pkg::S_DONE;
        end else if (mode != `CRBCD_MODE_DIR && mode != `CRBCD_MODE_IX1 &&
                     mode != `CRBCD_MODE_BRBIT && mode != `CRBCD_MODE_BITSC) begin
          // outside this decoder: treated as a two-byte no-op
          rd_d = 1'b0;
          state_d = crbcd_pkg::S_DONE;
        end
      end
      crbcd_pkg::S_DATA: begin
        state_d = crbcd_pkg::S_DONE;
        if (mode == `CRBCD_MODE_BRBIT) begin
          bit_d = |(mem_rdata & bit_mask); // RULE_06
          flags_d[`CRBCD_FLAG_C] = |(mem_rdata & bit_mask); // RULE_08
          addr_d = pc_q; // RULE_05
          rd_d = 1'b1;
          state_d = crbcd_pkg::S_REL;
        end else if (mode == `CRBCD_MODE_BITSC) begin
          // only reachable after a direct operand byte
          wdata_d = ir_q[0] ? (mem_rdata & ~bit_mask) : (mem_rdata | bit_mask); // RULE_03 RULE_10
          addr_d = ea_q;
          wr_d = 1'b1;
        end else begin
          if (fn_valid(fn)) begin
            flags_d[`CRBCD_FLAG_N] = alu_n;
            flags_d[`CRBCD_FLAG_Z] = alu_z;
            flags_d[`CRBCD_FLAG_C] = alu_c; // RULE_15
          end
          if (alu_wb && fn_valid(fn)) begin
            if (mode == `CRBCD_MODE_INHA) begin
              acc_d = alu_out; // RULE_01
            end else if (mode == `CRBCD_MODE_INHX) begin
              idx_d = alu_out; // RULE_01
            end else begin
              addr_d = ea_q; // RULE_17
              wdata_d = alu_out; // RULE_01
              wr_d = 1'b1; // RULE_17
            end
          end
          // register forms skip the done state to keep their three-cycle count
          if (mode == `CRBCD_MODE_INHA || mode == `CRBCD_MODE_INHX) begin
            cyc_d = 4'h1;
            done_d = 1'b1;
            state_d = crbcd_pkg::S_FETCH; // RULE_14
          end
        end
      end
      crbcd_pkg::S_REL: begin
        pc_d = next_pc; // RULE_09
        if (bit_q == ~ir_q[0]) begin
          pc_d = next_pc + {{8{mem_rdata[7]}}, mem_rdata}; // RULE_07
        end
        state_d = crbcd_pkg::S_DONE;
      end
      crbcd_pkg::S_DONE: begin
        // pad short paths up to the least cycle count of their form
        if (cyc_q < cyc_target(mode) && ir_q[7:4] != 4'h9 && ir_q[7:4] != 4'hB) begin
          state_d = crbcd_pkg::S_DONE;
        end else begin
          cyc_d = 4'h1;
          done_d = 1'b1;
          state_d = crbcd_pkg::S_FETCH;
        end
      end
      crbcd_pkg::S_HALT: begin
        cyc_d = cyc_q;
        // wake only on an asserted interrupt level; no vectoring here
        if (!irq_lvl_q) begin
          osc_stop_d = 1'b0;
          clk_stop_d = 1'b0;
          cyc_d = 4'h1;
          done_d = 1'b1;
          state_d = crbcd_pkg::S_FETCH;
        end
      end
      default: state_d = crbcd_pkg::S_FETCH;
    endcase
  end

  // level changes once stages two and three agree
  always_comb begin
    irq_lvl_d = irq_lvl_q;
    if (irq_s2_q == irq_s3_q) begin
      irq_lvl_d = irq_s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= crbcd_pkg::S_FETCH;
      pc_q <= `CRBCD_RST_PC;
      ea_q <= 16'h0000;
      ir_q <= 8'h00;
      acc_q <= 8'h00;
      idx_q <= 8'h00;
      flags_q <= `CRBCD_RST_FLAGS;
      cyc_q <= 4'h1;
      addr_q <= 16'h0000;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      osc_stop_q <= 1'b0;
      clk_stop_q <= 1'b0;
      done_q <= 1'b0;
      bit_q <= 1'b0;
      irq_s1_q <= 1'b1;
      irq_s2_q <= 1'b1;
      irq_s3_q <= 1'b1;
      irq_lvl_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      ea_q <= ea_d;
      ir_q <= ir_d;
      acc_q <= acc_d;
      idx_q <= idx_d;
      flags_q <= flags_d;
      cyc_q <= cyc_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wdata_q <= wdata_d;
      osc_stop_q <= osc_stop_d;
      clk_stop_q <= clk_stop_d;
      done_q <= done_d;
      bit_q <= bit_d;
      irq_s1_q <= irq_n_pin;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      irq_lvl_q <= irq_lvl_d;
    end
  end

  assign mem_addr = addr_q;
  assign mem_rd = rd_q;
  assign mem_wr = wr_q;
  assign mem_wdata = wdata_q;
  assign osc_stop = osc_stop_q;
  assign cpu_clk_stop = clk_stop_q;
  assign irq_pin_en = osc_stop_q; // RULE_11
  assign acc_value = acc_q;
  assign idx_value = idx_q;
  assign flags_value = flags_q;
  assign pc_value = pc_q;
  assign instr_done = done_q;

endmodule : crbcd_core

// file: test/crbcd_mem_model.sv
/*
  Byte memory standing on the far side of the core's bus.
  Assumes one access per cycle and read data due in the same cycle as the strobe.
*/
module crbcd_mem_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:511];
  logic [7:0] last_q = 8'h00;
  // no write-only places here; the bench keeps modify cycles off them
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr[8:0]] <= mem_wdata;
    end
    if (mem_rd) begin
      last_q <= mem[mem_addr[8:0]];
    end
  end
  // answer stands while the strobe is high; the core takes it at that cycle's end
  // idle bus shows the inverse of the last byte so a stale answer is never taken
  assign mem_rdata = mem_rd ? mem[mem_addr[8:0]] : ~last_q;
endmodule : crbcd_mem_model

// file: test/crbcd_core_assertions.sv
/*
  Port checker for the core.
  Assumes one clock and synchronous active-high reset.
*/
module crbcd_core_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic irq_n_pin,
  input wire logic osc_stop,
  input wire logic cpu_clk_stop,
  input wire logic irq_pin_en,
  input wire logic [4:0] flags_value,
  input wire logic instr_done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  chk_one_access: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
  chk_wr_single: assert property (mem_wr |=> !mem_wr)
    else $error("write strobe longer than one cycle");
  chk_rmw_addr: assert property (mem_wr |-> $past(mem_rd) && $past(mem_addr) == mem_addr)
    else $error("write not preceded by read of same address");
  chk_halt_outs: assert property (osc_stop |-> cpu_clk_stop && irq_pin_en)
    else $error("stop without clock halt or pin enable");
  chk_halt_quiet: assert property (cpu_clk_stop && $past(cpu_clk_stop) |-> !mem_rd && !mem_wr)
    else $error("bus access while halted");
  chk_halt_int_en: assert property ($rose(cpu_clk_stop) |-> !flags_value[3])
    else $error("halt entered with interrupts masked");
  chk_done_gap: assert property (instr_done |=> !instr_done [*2])
    else $error("instruction shorter than three cycles");
  chk_wake_cause: assert property ($fell(cpu_clk_stop) |-> !$past(irq_n_pin, 2))
    else $error("woke without interrupt pin low");
endmodule : crbcd_core_checker

bind crbcd_core crbcd_core_checker u_chk (.clk, .sys_rst, .mem_addr, .mem_rd, .mem_wr,
  .irq_n_pin, .osc_stop, .cpu_clk_stop, .irq_pin_en, .flags_value, .instr_done);

// file: test/crbcd_tb.sv
/*
  Self-checking bench for the core with a memory model.
  Assumes programs start at 0000 after reset.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, irq_n_pin, mem_rd, mem_wr, osc_stop, cpu_clk_stop, irq_pin_en, instr_done;
  logic [15:0] mem_addr, pc_value;
  logic [7:0] mem_wdata, mem_rdata, acc_value, idx_value;
  logic [4:0] flags_value;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wr = 0;
  int cyc = 0;

  crbcd_core DUT (.clk, .sys_rst, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
    .irq_n_pin, .osc_stop, .cpu_clk_stop, .irq_pin_en, .acc_value, .idx_value,
    .flags_value, .pc_value, .instr_done);
  crbcd_mem_model mem (.clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // counted on the falling edge, clear of the strobe's own update
  always @(negedge clk) begin
    if (mem_wr === 1'b1) n_wr++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic boot(input logic [7:0] prog[$]);
    @(posedge clk);
    #5 sys_rst = 1'b1;
    for (int i = 0; i < 512; i++) mem.mem[i] = 8'h00;
    foreach (prog[i]) mem.mem[i] = prog[i];
    n_wr = 0;
  endtask : boot

  task automatic go();
    repeat (20) @(posedge clk);
    #5 sys_rst = 1'b0;
  endtask : go

  // bounded wait for the end of one instruction; cyc is its length
  task automatic step();
    cyc = 0;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (instr_done !== 1'b1 && cyc < 60);
    if (cyc >= 60) begin
      n_mismatch++;
      $display("unexpected instr_done: expected 1 seen 0");
      summarize();
    end
  endtask : step

  task automatic t_shift();
    boot('{8'h38, 8'h40, 8'h38, 8'h40});
    mem.mem[9'h040] = 8'hC1;
    go();
    step();
    check("shift data", mem.mem[9'h040], 8'h82);
    step();
    check("shift cycles", 16'(cyc), 5);
    check("shift data", mem.mem[9'h040], 8'h04);
    check("shift flags", flags_value, 5'h09);
    check("writes", 16'(n_wr), 2);
    check("pc", pc_value, 16'h0004);
    $display("test shift done");
  endtask : t_shift

  task automatic t_inh();
    boot('{8'h4C, 8'h48, 8'h48, 8'h48, 8'h97, 8'h5C, 8'h58, 8'h9F, 8'h78, 8'h68, 8'h10});
    mem.mem[9'h012] = 8'h03;
    mem.mem[9'h022] = 8'h80;
    go();
    repeat (4) step();
    check("acc", acc_value, 8'h08);
    check("acc shift cycles", 16'(cyc), 3);
    step();
    check("idx", idx_value, 8'h08);
    check("copy cycles", 16'(cyc), 3);
    repeat (2) step();
    check("idx", idx_value, 8'h12);
    check("idx shift cycles", 16'(cyc), 3);
    step();
    check("acc", acc_value, 8'h12);
    check("writes", 16'(n_wr), 0);
    step();
    check("ix cycles", 16'(cyc), 5);
    check("ix data", mem.mem[9'h012], 8'h06);
    step();
    check("ix1 cycles", 16'(cyc), 6);
    check("ix1 data", mem.mem[9'h022], 8'h00);
    check("ix1 flags", flags_value, 5'h0B);
    $display("test inherent done");
  endtask : t_inh

  task automatic t_bits();
    logic [7:0] prog[$];
    logic [7:0] e80, e81;
    e80 = 8'h00;
    e81 = 8'hFF;
    for (int i = 0; i < 16; i++) begin
      prog.push_back(8'h10 + 8'(i));
      prog.push_back(i[0] ? 8'h81 : 8'h80);
    end
    boot(prog);
    mem.mem[9'h081] = 8'hFF;
    go();
    for (int i = 0; i < 16; i++) begin
      step();
      if (i[0]) e81[i >> 1] = 1'b0;
      else e80[i >> 1] = 1'b1;
      check("set byte", mem.mem[9'h080], e80);
      check("clear byte", mem.mem[9'h081], e81);
      if (i > 0) check("bit cycles", 16'(cyc), 5);
    end
    $display("test bits done");
  endtask : t_bits

  task automatic t_brbit();
    boot('{8'h00, 8'h40, 8'h05, 8'hBC, 8'h30});
    mem.mem[9'h008] = 8'h01;
    mem.mem[9'h009] = 8'h40;
    mem.mem[9'h00A] = 8'hF0;
    mem.mem[9'h00B] = 8'h03;
    mem.mem[9'h00C] = 8'h40;
    mem.mem[9'h00D] = 8'hF5;
    mem.mem[9'h040] = 8'h01;
    go();
    step();
    check("taken pc", pc_value, 16'h0008);
    check("carry", flags_value[0], 1'b1);
    step();
    check("untaken pc", pc_value, 16'h000B);
    check("carry", flags_value[0], 1'b1);
    check("branch cycles", 16'(cyc), 6);
    step();
    check("back pc", pc_value, 16'h0003);
    check("carry", flags_value[0], 1'b0);
    step();
    check("jump pc", pc_value, 16'h0030);
    check("jump cycles", 16'(cyc), 16'h0004);
    $display("test branch done");
  endtask : t_brbit

  task automatic t_ops();
    logic [7:0] e_acc[7] = '{8'h00, 8'hFF, 8'h7F, 8'h3F, 8'h3E, 8'h00, 8'h00};
    logic [4:0] e_flg[7] = '{5'h0A, 5'h0D, 5'h09, 5'h09, 5'h09, 5'h0B, 5'h0B};
    boot('{8'h40, 8'h43, 8'h44, 8'h47, 8'h4A, 8'h4F, 8'h41});
    go();
    for (int i = 0; i < 7; i++) begin
      step();
      check("op acc", acc_value, e_acc[i]);
      check("op flags", flags_value, e_flg[i]);
      check("op cycles", 16'(cyc), 16'h0003);
    end
    $display("test accumulator ops done");
  endtask : t_ops

  task automatic t_tst();
    boot('{8'h3D, 8'h40, 8'h39, 8'h40, 8'h36, 8'h40});
    mem.mem[9'h040] = 8'h80;
    go();
    step();
    check("test writes", 16'(n_wr), 0);
    check("test flags", flags_value, 5'h0C);
    step();
    check("rol data", mem.mem[9'h040], 8'h00);
    check("rol flags", flags_value, 5'h0B);
    step();
    check("ror data", mem.mem[9'h040], 8'h80);
    check("ror flags", flags_value, 5'h0C);
    $display("test flags done");
  endtask : t_tst

  task automatic t_halt();
    // copies after the wait give the synchronised pin time to go high before stop
    boot('{8'h8F, 8'h97, 8'h97, 8'h8E});
    go();
    repeat (10) @(posedge clk);
    #5 check("clock halt", cpu_clk_stop, 1'b1);
    check("osc", osc_stop, 1'b0);
    check("mask", flags_value[3], 1'b0);
    irq_n_pin = 1'b0;
    step();
    check("wake pc", pc_value, 16'h0001);
    #4 irq_n_pin = 1'b1;
    repeat (10) @(posedge clk);
    #5 check("osc", osc_stop, 1'b1);
    check("pin enable", irq_pin_en, 1'b1);
    irq_n_pin = 1'b0;
    step();
    check("wake pc", pc_value, 16'h0004);
    check("osc", osc_stop, 1'b0);
    #4 irq_n_pin = 1'b1;
    $display("test halt done");
  endtask : t_halt

  initial begin
    sys_rst = 1'b1;
    irq_n_pin = 1'b1;
    t_shift();
    t_inh();
    t_bits();
    t_brbit();
    t_tst();
    t_ops();
    t_halt();
    summarize();
  end
endmodule : testbench
